// ===== hdl/adcs_pkg.sv
// Package of constants for the converter control sequencer.
package adcs_pkg;
    // -------------------------------------------------------------------
    // Register map
    // -------------------------------------------------------------------
    localparam logic [3:0] ADDR_PIN_SELECT  = 4'h0;
    localparam logic [3:0] ADDR_CONTROL     = 4'h1;
    localparam logic [3:0] ADDR_OFFSET      = 4'h2;
    localparam logic [3:0] ADDR_RESULT_HIGH = 4'h3;
    localparam logic [3:0] ADDR_RESULT_LOW  = 4'h4;
    localparam logic [3:0] ADDR_STATUS      = 4'h5;
    // -------------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------------
    localparam int CTL_REF_BIT   = 7;
    localparam int CTL_PRE_HI    = 6;
    localparam int CTL_PRE_LO    = 5;
    localparam int CTL_RUN_BIT   = 4;
    localparam int CTL_PWR_BIT   = 3;
    localparam int OFS_EN_BIT    = 7;
    localparam int OFS_SIGN_BIT  = 6;
    localparam int OFS_MAG_HI    = 5;
    localparam int OFS_MAG_LO    = 3;
    localparam int STS_DONE_BIT  = 0;
    localparam int STS_WAKE_BIT  = 1;
    localparam int STS_SLEEP_BIT = 2;
    localparam logic [7:0] OFS_MASK = 8'hf8;
    // -------------------------------------------------------------------
    // Reset values and timing
    // -------------------------------------------------------------------
    localparam logic [7:0] RST_PIN_SELECT = 8'h00;
    localparam logic [7:0] RST_CONTROL    = 8'h00;
    localparam logic [7:0] RST_OFFSET     = 8'h00;
    localparam int RES_BITS       = 10;
    localparam int SYS_OVERHEAD   = 3;
    localparam int HALF_OVERHEAD  = 3; // 1.5 converter clocks in halves.
    localparam int SAMPLE_CLOCKS  = 4;
    localparam logic [4:0] DIV_4  = 5'h04;
    localparam logic [4:0] DIV_1  = 5'h01;
    localparam logic [4:0] DIV_16 = 5'h10;
    localparam logic [4:0] DIV_2  = 5'h02;
    typedef enum logic [2:0] {
        ADCS_IDLE, ADCS_SYS, ADCS_DIG, ADCS_SAMPLE, ADCS_CONV, ADCS_DONE
    } adcs_state_type;
endpackage : adcs_pkg

// ===== hdl/adcs_prescaler.sv
// Prescaler producing converter half-period ticks from the system clock.
`timescale 1ns/10ps
module adcs_prescaler
    import adcs_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    adcs_tick_if.source tick
);
    // -------------------------------------------------------------------
    // Divider selection
    // -------------------------------------------------------------------
    function automatic logic [4:0] adcs_divisor(input logic [1:0] code);
        case (code)
            2'b00:   adcs_divisor = DIV_4;
            2'b01:   adcs_divisor = DIV_1;
            2'b10:   adcs_divisor = DIV_16;
            default: adcs_divisor = DIV_2;
        endcase
    endfunction : adcs_divisor

    logic [4:0] count;
    logic [4:0] limit;
    logic       wrap;
    // Half ticks are produced twice per converter period, so the counter
    // runs over the divisor in system clocks; divide-by-one ticks always.
    // prescale selection
    assign limit = adcs_divisor(tick.prescale);
    assign wrap  = (count >= limit - 5'h01);
    assign tick.half_tick = tick.enable &&
                            ((limit == DIV_1) || wrap ||
                             (count == (limit >> 1) - 5'h01));

    // Counter restarts whenever the sequencer is not running.
    always_ff @(posedge clk_i) begin
        if (rst_i || !tick.enable || wrap) begin
            count <= 5'h00;
        end else begin
            count <= count + 5'h01;
        end
    end
endmodule : adcs_prescaler

// ===== hdl/adcs_tick_if.sv
// Interface carrying the converter half-clock tick between modules.
`timescale 1ns/10ps
interface adcs_tick_if;
    logic [1:0] prescale;
    logic       enable;
    logic       half_tick;
    modport source (input prescale, input enable, output half_tick);
    modport sink   (output prescale, output enable, input half_tick);
endinterface : adcs_tick_if

// ===== hdl/adcs_top.sv
// Converter control sequencer with a classic Wishbone register slave.
`timescale 1ns/10ps
module adcs_top
    import adcs_pkg::*;
#(
    parameter int RES_WIDTH = RES_BITS
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [3:0]           wb_adr_i,
    input  wire logic [7:0]           wb_dat_i,
    input  wire logic                 wb_sel_i,
    output logic [7:0]                wb_dat_o,
    output logic                      wb_ack_o,
    input  wire logic                 cpu_sleep_i,
    input  wire logic                 ext_int_enable_i,
    input  wire logic                 comparator_i,
    output logic [7:0]                analog_pin_enable_bits_o,
    output logic                      first_pin_ext_int_o,
    output logic                      first_pin_port_o,
    output logic                      reference_pin_select_o,
    output logic                      reference_pin_port_o,
    output logic                      resistor_ref_on_o,
    output logic [2:0]                channel_select_o,
    output logic                      sample_o,
    output logic [RES_WIDTH-1:0]      dac_code_o,
    output logic                      conversion_done_flag_o,
    output logic                      wake_o
);
    // -------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------
    logic [7:0]  analog_pin_select;
    logic [7:0]  converter_control;
    logic [7:0]  offset_calibration;
    logic [7:0]  result_high_register;
    logic [7:0]  result_low_register;
    logic        conversion_done_flag;
    logic        conversion_wake_enable;
    logic        sleep_shutoff;
    adcs_state_type state;
    logic [4:0]  phase_count;
    logic [3:0]  bit_index;
    logic [RES_WIDTH-1:0] trial;

    adcs_tick_if tick_bus ();

    adcs_prescaler u_prescaler (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .tick  (tick_bus.source)
    );

    // -------------------------------------------------------------------
    // Bus decode
    // -------------------------------------------------------------------
    logic bus_req;
    logic bus_wr;
    logic wr_pin;
    logic wr_ctl;
    logic wr_ofs;
    logic wr_sts;
    logic run_set;
    logic finish;
    logic run_bit;
    logic powered;
    logic [7:0] read_mux;
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr  = bus_req && wb_we_i && wb_sel_i;
    assign wr_pin  = bus_wr && (wb_adr_i == ADDR_PIN_SELECT);
    assign wr_ctl  = bus_wr && (wb_adr_i == ADDR_CONTROL);
    assign wr_ofs  = bus_wr && (wb_adr_i == ADDR_OFFSET);
    assign wr_sts  = bus_wr && (wb_adr_i == ADDR_STATUS);
    assign run_bit = converter_control[CTL_RUN_BIT];
    assign powered = converter_control[CTL_PWR_BIT];
    assign finish  = (state == ADCS_DONE);
    assign run_set = wr_ctl && wb_dat_i[CTL_RUN_BIT] && powered;

    // Unmapped addresses read zero and still acknowledge.
    always_comb begin
        case (wb_adr_i)
            ADDR_PIN_SELECT:  read_mux = analog_pin_select;
            ADDR_CONTROL:     read_mux = converter_control;
            ADDR_OFFSET:      read_mux = offset_calibration & OFS_MASK;
            ADDR_RESULT_HIGH: read_mux = result_high_register;
            ADDR_RESULT_LOW:  read_mux = result_low_register;
            ADDR_STATUS:      read_mux = {5'h00, sleep_shutoff,
                                          conversion_wake_enable,
                                          conversion_done_flag};
            default:          read_mux = 8'h00;
        endcase
    end

    // Single-wait-state acknowledge: ack rises one edge after the request.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 8'h00;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? read_mux : 8'h00;
        end
    end

    // -------------------------------------------------------------------
    // Configuration registers
    // -------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            analog_pin_select  <= RST_PIN_SELECT;
            offset_calibration <= RST_OFFSET;
        end else begin
            if (wr_pin) begin
                analog_pin_select <= wb_dat_i;
            end
            if (wr_ofs) begin
                offset_calibration <= wb_dat_i & OFS_MASK;
            end
        end
    end

    // Control word: run bit is owned by hardware apart from the set.
    // completion clears run
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            converter_control <= RST_CONTROL;
        end else begin
            if (wr_ctl) begin
                converter_control <= {wb_dat_i[7:5],
                                      (run_bit && !finish) || run_set,
                                      wb_dat_i[3:0]};
            end else if (finish || sleep_shutoff || !powered) begin
                converter_control[CTL_RUN_BIT] <= 1'b0;
            end
        end
    end

    // Done flag and wake enable; a completion beats a software clear.
    // flag ignores masks
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conversion_done_flag   <= 1'b0;
            conversion_wake_enable <= 1'b0;
        end else begin
            if (wr_sts) begin
                conversion_wake_enable <= wb_dat_i[STS_WAKE_BIT];
            end
            if (finish) begin
                conversion_done_flag <= 1'b1;
            end else if (wr_sts && !wb_dat_i[STS_DONE_BIT]) begin
                conversion_done_flag <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------------
    // Conversion sequencer
    // -------------------------------------------------------------------
    logic half;
    logic full_tick;
    assign tick_bus.prescale = converter_control[CTL_PRE_HI:CTL_PRE_LO];
    assign tick_bus.enable   = (state != ADCS_IDLE) && (state != ADCS_SYS);
    assign half              = tick_bus.half_tick;
    assign full_tick         = half && phase_count[0];

    // Offset-trimmed result with saturation.
    function automatic logic [RES_WIDTH-1:0] adcs_trim(
        input logic [RES_WIDTH-1:0] raw,
        input logic [7:0] ofs
    );
        logic [RES_WIDTH:0] mag;
        logic [RES_WIDTH:0] sum;
        mag = {{(RES_WIDTH-2){1'b0}}, ofs[OFS_MAG_HI:OFS_MAG_LO]};
        sum = {1'b0, raw};
        if (!ofs[OFS_EN_BIT]) begin
            adcs_trim = raw;
        end else if (ofs[OFS_SIGN_BIT]) begin
            sum = sum + mag;
            adcs_trim = sum[RES_WIDTH] ? {RES_WIDTH{1'b1}}
                                       : sum[RES_WIDTH-1:0];
        end else begin
            adcs_trim = (sum < mag) ? {RES_WIDTH{1'b0}}
                                    : RES_WIDTH'(sum - mag);
        end
    endfunction : adcs_trim

    logic [RES_WIDTH-1:0] final_code;
    assign final_code = comparator_i ? trial
                                     : trial & ~(RES_WIDTH'(1) << bit_index);
    logic [RES_WIDTH-1:0] trimmed;
    assign trimmed = adcs_trim(final_code, offset_calibration);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state       <= ADCS_IDLE;
            phase_count <= 5'h00;
            bit_index   <= 4'h0;
            trial       <= '0;
        end else begin
            case (state)
                ADCS_IDLE: begin
                    phase_count <= 5'h00;
                    // Start from the stored run bit, so that a set landing
                    // on the completion cycle is not left stranded.
                    if (run_bit) begin
                        state <= ADCS_SYS;
                    end
                end
                ADCS_SYS: begin
                    phase_count <= phase_count + 5'h01;
                    if (phase_count == 5'(SYS_OVERHEAD - 1)) begin
                        phase_count <= 5'h00;
                        state       <= ADCS_DIG;
                    end
                end
                ADCS_DIG: if (half) begin
                    phase_count <= phase_count + 5'h01;
                    if (phase_count == 5'(HALF_OVERHEAD - 1)) begin
                        phase_count <= 5'h01;
                        state       <= ADCS_SAMPLE;
                    end
                end
                ADCS_SAMPLE: if (half) begin
                    phase_count <= phase_count + 5'h01;
                    if (phase_count == 5'(2 * SAMPLE_CLOCKS)) begin
                        phase_count <= 5'h00;
                        bit_index   <= 4'(RES_WIDTH - 1);
                        trial       <= RES_WIDTH'(1) << (RES_WIDTH - 1);
                        state       <= ADCS_CONV;
                    end
                end
                ADCS_CONV: if (half) begin
                    phase_count <= phase_count + 5'h01;
                    if (full_tick) begin
                        if (bit_index == 4'h0) begin
                            trial <= final_code;
                            state <= ADCS_DONE;
                        end else begin
                            trial <= final_code |
                                     (RES_WIDTH'(1) << (bit_index - 4'h1));
                            bit_index <= bit_index - 4'h1;
                        end
                    end
                end
                ADCS_DONE: state <= ADCS_IDLE;
                default:   state <= ADCS_IDLE;
            endcase
            if (sleep_shutoff || !powered) begin
                state <= ADCS_IDLE;
            end
        end
    end

    // Results and sleep handling.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_high_register <= 8'h00;
            result_low_register  <= 8'h00;
            sleep_shutoff        <= 1'b0;
            wake_o               <= 1'b0;
        end else begin
            if (state == ADCS_CONV && full_tick && bit_index == 4'h0) begin
                result_high_register <= 8'(trimmed >> 2);
                result_low_register  <= {6'h00, trimmed[1:0]};
            end
            wake_o <= finish && cpu_sleep_i && conversion_wake_enable;
            if (!cpu_sleep_i) begin
                sleep_shutoff <= 1'b0;
            end else if (finish && !conversion_wake_enable) begin
                sleep_shutoff <= 1'b1;
            end
        end
    end

    // -------------------------------------------------------------------
    // Pin and analog outputs
    // -------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            analog_pin_enable_bits_o <= 8'h00;
            first_pin_ext_int_o      <= 1'b0;
            first_pin_port_o         <= 1'b1;
            reference_pin_select_o   <= 1'b0;
            reference_pin_port_o     <= 1'b1;
            resistor_ref_on_o        <= 1'b0;
            channel_select_o         <= 3'h0;
            sample_o                 <= 1'b0;
            dac_code_o               <= '0;
            conversion_done_flag_o   <= 1'b0;
        end else begin
            analog_pin_enable_bits_o <= analog_pin_select;
            first_pin_ext_int_o <= ext_int_enable_i;
            first_pin_port_o    <= !ext_int_enable_i && !analog_pin_select[0];
            reference_pin_select_o <= converter_control[CTL_REF_BIT];
            reference_pin_port_o   <= !converter_control[CTL_REF_BIT];
            resistor_ref_on_o <= powered && !sleep_shutoff;
            channel_select_o <= converter_control[2:0];
            sample_o         <= (state == ADCS_SAMPLE);
            dac_code_o       <= trial;
            conversion_done_flag_o <= conversion_done_flag;
        end
    end
endmodule : adcs_top

// ===== tb/adcs_analog_model.sv
// Behavioural model of the analog comparator behind the converter.
`timescale 1ns/10ps
module adcs_analog_model (
    input  wire logic [9:0] dac_code_i,
    input  wire logic [9:0] level_i,
    output logic            comparator_o
);
    // trial keep decision
    // A trial bit is kept while the trial code does not exceed the input.
    assign comparator_o = (dac_code_i <= level_i);
endmodule : adcs_analog_model

// ===== tb/adcs_top_bench.sv
// Self-checking bench for the converter control sequencer.
`timescale 1ns/10ps
module adcs_top_bench
    import adcs_pkg::*;
();
    logic       clk_i, rst_i, cyc, stb, we, ack, sleep, ext_int, comp;
    logic       sel, sel_use;
    logic       first_int, first_port, ref_sel, ref_port, ref_on, smp;
    logic       done, wake;
    logic [3:0] adr;
    logic [7:0] wdat, rdat, q, pin_en;
    logic [2:0] chan;
    logic [9:0] dac, level, res;
    int         err_total, samples_checked, wake_seen;
    adcs_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
        .cpu_sleep_i(sleep), .ext_int_enable_i(ext_int),
        .comparator_i(comp), .analog_pin_enable_bits_o(pin_en),
        .first_pin_ext_int_o(first_int), .first_pin_port_o(first_port),
        .reference_pin_select_o(ref_sel), .reference_pin_port_o(ref_port),
        .resistor_ref_on_o(ref_on), .channel_select_o(chan),
        .sample_o(smp), .dac_code_o(dac), .conversion_done_flag_o(done),
        .wake_o(wake));
    adcs_analog_model partner (.dac_code_i(dac), .level_i(level),
        .comparator_o(comp));
    // Free-running system clock at 10 MHz.
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // Wake pulses are counted here so that polling cannot miss one.
    always @(posedge clk_i) begin
        if (wake === 1'b1) wake_seen++;
    end
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results
    task automatic check_value(input logic [9:0] got, input logic [9:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : check_value
    // One classic cycle; the request is held until ack is sampled high.
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [7:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= sel_use;
        adr <= a;
        wdat <= d;
        // Only the watchdog ends a wait for an answer that never comes.
        forever begin
            @(posedge clk_i);
            if (ack === 1'b1) break;
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
        // The acknowledge must stand for one cycle only.
        check_value({9'h0, ack}, 10'h0);
    endtask : bus
    // Select, wait acquisition, start, poll until the run bit drops.
    task automatic convert(input logic [1:0] pre, input logic poke,
                           input logic [7:0] st, input logic [9:0] exp);
        int n;
        bus(1'b1, ADDR_CONTROL, {1'b0, pre, 2'b01, 3'(pre)});
        repeat (20) @(posedge clk_i);
        bus(1'b1, ADDR_CONTROL, {1'b0, pre, 2'b11, 3'(pre)});
        if (poke) begin
            bus(1'b1, ADDR_CONTROL, {1'b0, pre, 2'b01, 3'(pre)});
            bus(1'b0, ADDR_CONTROL, 8'h00);
            check_value({9'h0, q[CTL_RUN_BIT]}, 10'h1);
        end
        q = 8'h10;
        n = 0;
        while (q[CTL_RUN_BIT] === 1'b1 && n < 300) begin
            bus(1'b0, ADDR_CONTROL, 8'h00);
            n++;
        end
        bus(1'b0, ADDR_STATUS, 8'h00);
        check_value({2'b0, q}, {2'b0, st});
        bus(1'b0, ADDR_RESULT_HIGH, 8'h00);
        res[9:2] = q;
        bus(1'b0, ADDR_RESULT_LOW, 8'h00);
        res[1:0] = q[1:0];
        check_value(res, exp);
        bus(1'b1, ADDR_STATUS, 8'h00);
        bus(1'b0, ADDR_RESULT_HIGH, 8'h00);
        check_value({2'b0, q}, {2'b0, exp[9:2]});
        repeat (40) @(posedge clk_i);
    endtask : convert
    // Watchdog cuts a hang short well beyond the expected run time.
    initial begin
        repeat (30000) @(posedge clk_i);
        err_total++;
        $display("BAD %0t watchdog expired", $time);
        results();
    end
    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        logic [3:0] adrs [5];
        logic [9:0] lv [4];
        logic [7:0] ofs [3];
        logic [9:0] oexp [3];
        adrs = '{ADDR_PIN_SELECT, ADDR_CONTROL, ADDR_OFFSET, ADDR_STATUS,
                 4'hf};
        lv = '{10'h2a5, 10'h0c3, 10'h3fe, 10'h155};
        ofs = '{8'hd8, 8'ha8, 8'h58};
        oexp = '{10'h158, 10'h150, 10'h155};
        {cyc, stb, we, sel, sleep, ext_int} = 6'h00;
        sel_use = 1'b1;
        adr = 4'h0;
        wdat = 8'h00;
        level = 10'h000;
        err_total = 0;
        samples_checked = 0;
        wake_seen = 0;
        rst_i = 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check_value({8'h0, first_port, ref_port}, 10'h3);
        foreach (adrs[i]) begin
            bus(1'b0, adrs[i], 8'h00);
            check_value({2'b0, q}, 10'h000);
        end
        bus(1'b1, ADDR_PIN_SELECT, 8'ha5);
        bus(1'b0, ADDR_PIN_SELECT, 8'h00);
        check_value({2'b0, q}, 10'h0a5);
        check_value({1'b0, pin_en, first_port}, 10'h14a);
        bus(1'b1, ADDR_PIN_SELECT, 8'ha4);
        ext_int <= 1'b1;
        repeat (3) @(posedge clk_i);
        check_value({8'h0, first_int, first_port}, 10'h2);
        ext_int <= 1'b0;
        repeat (3) @(posedge clk_i);
        check_value({8'h0, first_int, first_port}, 10'h1);
        // A write with its byte lane off is acknowledged but dropped.
        sel_use = 1'b0;
        bus(1'b1, ADDR_PIN_SELECT, 8'h5a);
        sel_use = 1'b1;
        bus(1'b0, ADDR_PIN_SELECT, 8'h00);
        check_value({2'b0, q}, 10'h0a4);
        bus(1'b1, ADDR_OFFSET, 8'hff);
        bus(1'b0, ADDR_OFFSET, 8'h00);
        check_value({2'b0, q}, 10'h0f8);
        bus(1'b1, ADDR_OFFSET, 8'h00);
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, ADDR_CONTROL, {5'h10, 3'(i)});
            repeat (2) @(posedge clk_i);
            check_value({5'h0, chan, ref_sel, ref_port},
                        {5'h0, 3'(i), 2'b10});
        end
        bus(1'b1, ADDR_CONTROL, 8'h10);
        bus(1'b0, ADDR_CONTROL, 8'h00);
        check_value({1'b0, q, ref_on}, 10'h000);
        for (int p = 0; p < 4; p++) begin
            level = lv[p];
            convert(2'(p), p == 2, 8'h01, lv[p]);
            check_value({9'h0, ref_on}, 10'h1);
        end
        foreach (ofs[i]) begin
            bus(1'b1, ADDR_OFFSET, ofs[i]);
            convert(2'b11, 1'b0, 8'h01, oexp[i]);
        end
        bus(1'b1, ADDR_OFFSET, 8'h00);
        bus(1'b1, ADDR_STATUS, 8'h02);
        sleep <= 1'b1;
        convert(2'b01, 1'b0, 8'h03, 10'h155);
        check_value(10'(wake_seen), 10'h1);
        sleep <= 1'b0;
        repeat (3) @(posedge clk_i);
        sleep <= 1'b1;
        convert(2'b01, 1'b0, 8'h05, 10'h155);
        check_value({9'h0, ref_on}, 10'h0);
        sleep <= 1'b0;
        repeat (3) @(posedge clk_i);
        bus(1'b0, ADDR_STATUS, 8'h00);
        check_value({1'b0, q, ref_on}, 10'h001);
        results();
    end
endmodule : adcs_top_bench

// ===== tb/adcs_top_properties.sv
// Concurrent checks on the ports of the converter sequencer top.
`timescale 1ns/10ps
module adcs_top_checker (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       wb_cyc_i,
    input  wire logic       wb_stb_i,
    input  wire logic [7:0] wb_dat_o,
    input  wire logic       wb_ack_o,
    input  wire logic [7:0] analog_pin_enable_bits_o,
    input  wire logic       first_pin_ext_int_o,
    input  wire logic       first_pin_port_o,
    input  wire logic       reference_pin_select_o,
    input  wire logic       reference_pin_port_o,
    input  wire logic       sample_o,
    input  wire logic       conversion_done_flag_o,
    input  wire logic       wake_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ---------------------------------------------------------------
    // Bus answer
    // ---------------------------------------------------------------
    chk_ack_answer: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o)
        |=> wb_ack_o) else $error("ack missing one cycle after request");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 8'h00)
        else $error("read data not zero outside ack");
    // ---------------------------------------------------------------
    // Pin functions
    // ---------------------------------------------------------------
    chk_first_port: assert property (
        (first_pin_ext_int_o || analog_pin_enable_bits_o[0])
        |-> !first_pin_port_o) else $error("first pin port not yielded");
    chk_ref_port: assert property (
        reference_pin_port_o == !reference_pin_select_o)
        else $error("reference pin port function wrong");
    // ---------------------------------------------------------------
    // Conversion sequence
    // ---------------------------------------------------------------
    chk_sample_min: assert property ($rose(sample_o) |=> sample_o)
        else $error("sample phase too short");
    chk_done_span: assert property (
        $fell(sample_o) |-> ##[4:400] $rose(conversion_done_flag_o))
        else $error("done flag late after sampling");
    chk_done_quiet: assert property (
        $rose(conversion_done_flag_o) |-> !sample_o)
        else $error("done flag while still sampling");
    chk_wake_pulse: assert property (wake_o |=> !wake_o)
        else $error("wake longer than one cycle");
endmodule : adcs_top_checker

bind adcs_top adcs_top_checker u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .analog_pin_enable_bits_o(analog_pin_enable_bits_o),
    .first_pin_ext_int_o(first_pin_ext_int_o),
    .first_pin_port_o(first_pin_port_o),
    .reference_pin_select_o(reference_pin_select_o),
    .reference_pin_port_o(reference_pin_port_o), .sample_o(sample_o),
    .conversion_done_flag_o(conversion_done_flag_o), .wake_o(wake_o));
